// ---- rtl/control_gate.sv ----
// Gates control bits by the halting debug enable
`timescale 1ns/1ps
`default_nettype none
module control_gate (
    debug_ctrl_if.gate ctrl
);
    // Disabled debug makes all other control bits inert
    assign ctrl.effective_halt = ctrl.debug_enable & ctrl.halt_request;
    assign ctrl.effective_step = ctrl.debug_enable & ctrl.step_enable;
    assign ctrl.effective_mask = ctrl.debug_enable & ctrl.mask_request;
endmodule // control_gate
`default_nettype wire

// ---- rtl/halting_debug_control_status.sv ----
// Halting debug control and status register of the core
//
// Contract
// - Writes need unlock key in upper halfword
// - Debug disabled makes other control bits inert
// - Reset-seen flag sticky, cleared by read
// - Retired flag set on completion, read clears
// - Retired flag undefined under lockup or halt
// - Lockup bit set, cleared entering debug
// - Lockup reads one only via access port
// - Sleep bit mirrors core sleeping
// - Halted bit mirrors debug state
// - Selector write clears, completion sets ready
// - Ready flag meaningful only in debug state
// - Mask bit masks service, tick, external interrupts
// - Mask bit undefined when debug disabled
// - Halt request bit, cleared on system reset
// - Enable writable only from access port
// - Step enable bit, undefined at power-on
`timescale 1ns/1ps
`default_nettype none
module halting_debug_control_status (
    input  wire logic                      clock_in,
    input  wire logic                      reset_in,
    input  wire logic                      system_reset_in,
    input  wire logic                      write_in,
    input  wire logic                      read_in,
    input  wire logic                      from_access_port_in,
    input  wire logic [31:0]               write_data_in,
    input  wire logic                      selector_write_in,
    input  wire logic                      transfer_done_in,
    input  wire logic                      instruction_done_in,
    input  wire debug_status_pkg::core_state_e core_state_in,
    output var  logic [31:0]               read_data_out,
    output var  logic                      halt_out,
    output var  logic                      step_out,
    output var  logic                      mask_interrupts_out
);
    import debug_status_pkg::*;

    debug_ctrl_if ctrl ();

    logic key_ok;
    logic write_ok;
    logic debug_enable;
    logic halt_request;
    logic step_enable;
    logic mask_request;
    logic reset_seen_flag;
    logic instruction_retired_flag;
    logic transfer_ready_flag;
    logic lockup_status;
    logic in_debug;
    logic sleeping;
    logic next_lockup_status;
    logic [31:0] next_read_data;

    assign in_debug = (core_state_in == CORE_HALTED);
    assign sleeping = (core_state_in == CORE_SLEEP);

    // Whole write dropped on a key mismatch
    assign key_ok   = (write_data_in[31:KEY_LSB] == UNLOCK_KEY);
    assign write_ok = write_in & key_ok;

    // Enable written only from the access port, cleared at power-on
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            debug_enable <= CTRL_RESET_VAL;
        end else if (write_ok && from_access_port_in) begin
            debug_enable <= write_data_in[BIT_DEBUG_EN];
        end
    end

    // Halt request, also cleared by system reset
    always_ff @(posedge clock_in) begin
        if (reset_in || system_reset_in) begin
            halt_request <= CTRL_RESET_VAL;
        end else if (write_ok) begin
            halt_request <= write_data_in[BIT_HALT];
        end
    end

    // Step and mask: undefined at power-on, zero chosen for determinism
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            step_enable  <= CTRL_RESET_VAL;
            mask_request <= CTRL_RESET_VAL;
        end else if (write_ok) begin
            step_enable  <= write_data_in[BIT_STEP];
            mask_request <= write_data_in[BIT_MASK_INTS];
        end
    end

    assign ctrl.debug_enable = debug_enable;
    assign ctrl.halt_request = halt_request;
    assign ctrl.step_enable  = step_enable;
    assign ctrl.mask_request = mask_request;

    control_gate u_gate (
        .ctrl (ctrl.gate)
    );

    // Core-facing controls registered straight from the gate
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            halt_out            <= 1'b0;
            step_out            <= 1'b0;
            mask_interrupts_out <= 1'b0;
        end else begin
            halt_out            <= ctrl.effective_halt;
            step_out            <= ctrl.effective_step;
            mask_interrupts_out <= ctrl.effective_mask;
        end
    end

    // Any reset leaves a trace the debugger can see
    sticky_flag u_reset_seen (
        .clock_in       (clock_in),
        .reset_in       (reset_in),
        .reset_value_in (RESET_SEEN_INIT),
        .set_in         (system_reset_in),
        .clear_in       (read_in),
        .flag_out       (reset_seen_flag)
    );

    // Retirement counted only outside debug state
    sticky_flag u_retired (
        .clock_in       (clock_in),
        .reset_in       (reset_in),
        .reset_value_in (CTRL_RESET_VAL),
        .set_in         (instruction_done_in && !in_debug),
        .clear_in       (read_in),
        .flag_out       (instruction_retired_flag)
    );

    // Ready handshake: selector write clears, completion sets
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            transfer_ready_flag <= CTRL_RESET_VAL;
        end else if (transfer_done_in) begin
            transfer_ready_flag <= 1'b1;
        end else if (selector_write_in) begin
            transfer_ready_flag <= 1'b0;
        end
    end

    // Lockup tracks core, forced clear on debug entry
    always_comb begin
        next_lockup_status = (core_state_in == CORE_LOCKED);
        if (in_debug) begin
            next_lockup_status = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            lockup_status <= 1'b0;
        end else begin
            lockup_status <= next_lockup_status;
        end
    end

    // Read word; key field returns status, reserved bits zero
    always_comb begin
        next_read_data                 = ZERO_WORD;
        next_read_data[BIT_RESET_SEEN] = reset_seen_flag;
        next_read_data[BIT_RETIRED]    = instruction_retired_flag;
        next_read_data[BIT_LOCKUP]     = lockup_status & from_access_port_in;
        next_read_data[BIT_SLEEP]      = sleeping;
        next_read_data[BIT_HALTED]     = in_debug;
        next_read_data[BIT_XFER_READY] = transfer_ready_flag;
        next_read_data[BIT_MASK_INTS]  = mask_request;
        next_read_data[BIT_STEP]       = step_enable;
        next_read_data[BIT_HALT]       = halt_request;
        next_read_data[BIT_DEBUG_EN]   = debug_enable;
    end

    // Read data registered; sampled with the read strobe
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            read_data_out <= ZERO_WORD;
        end else if (read_in) begin
            read_data_out <= next_read_data;
        end
    end

    // Checks
    a_key_guard: assert property (@(posedge clock_in) disable iff (reset_in)
        write_in && !key_ok && !system_reset_in |=> $stable(halt_request))
        else $error("keyless write changed halt");

    a_key_others: assert property (@(posedge clock_in) disable iff (reset_in)
        write_in && !key_ok |=> $stable(debug_enable) && $stable(step_enable)
            && $stable(mask_request))
        else $error("keyless write changed control");

    a_gate_enable: assert property (@(posedge clock_in) disable iff (reset_in)
        !debug_enable |=> !halt_out && !step_out && !mask_interrupts_out)
        else $error("control active while debug disabled");

    a_reset_seen: assert property (@(posedge clock_in) disable iff (reset_in)
        system_reset_in |=> reset_seen_flag)
        else $error("reset not recorded");

    a_read_clears: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in && !system_reset_in |=> !reset_seen_flag)
        else $error("read did not clear reset flag");

    a_reset_read: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in |=> read_data_out[BIT_RESET_SEEN] == $past(reset_seen_flag))
        else $error("reset flag read wrong");

    a_retire_set: assert property (@(posedge clock_in) disable iff (reset_in)
        instruction_done_in && !in_debug |=> instruction_retired_flag)
        else $error("retirement lost");

    a_retire_read: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in && !instruction_done_in |=> !instruction_retired_flag)
        else $error("read did not clear retired flag");

    a_retire_debug: assert property (@(posedge clock_in) disable iff (reset_in)
        instruction_done_in && in_debug && !read_in |=> $stable(instruction_retired_flag))
        else $error("retirement counted in debug");

    a_retire_bit: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in |=> read_data_out[BIT_RETIRED] == $past(instruction_retired_flag))
        else $error("retired flag read wrong");

    a_lockup_track: assert property (@(posedge clock_in) disable iff (reset_in)
        core_state_in == CORE_LOCKED |=> lockup_status)
        else $error("lockup not reported");

    a_lockup_debug: assert property (@(posedge clock_in) disable iff (reset_in)
        in_debug |=> !lockup_status)
        else $error("lockup held in debug");

    a_lockup_port: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in && !from_access_port_in |=> !read_data_out[BIT_LOCKUP])
        else $error("lockup visible to core");

    a_sleep_read: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in |=> read_data_out[BIT_SLEEP] == $past(sleeping))
        else $error("sleep bit wrong");

    a_halt_read: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in |=> read_data_out[BIT_HALTED] == $past(in_debug))
        else $error("halted bit wrong");

    a_ready_clear: assert property (@(posedge clock_in) disable iff (reset_in)
        selector_write_in && !transfer_done_in |=> !transfer_ready_flag)
        else $error("ready not cleared");

    a_ready_set: assert property (@(posedge clock_in) disable iff (reset_in)
        transfer_done_in |=> transfer_ready_flag)
        else $error("ready not set");

    a_ready_read: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in |=> read_data_out[BIT_XFER_READY] == $past(transfer_ready_flag))
        else $error("ready flag read wrong");

    a_mask_out: assert property (@(posedge clock_in) disable iff (reset_in)
        debug_enable && mask_request |=> mask_interrupts_out)
        else $error("mask not applied");

    a_sysreset_halt: assert property (@(posedge clock_in) disable iff (reset_in)
        system_reset_in |=> !halt_request ##1 !halt_out)
        else $error("halt survived system reset");

    a_halt_out: assert property (@(posedge clock_in) disable iff (reset_in)
        debug_enable && halt_request |=> halt_out)
        else $error("halt request not applied");

    a_halt_bit: assert property (@(posedge clock_in) disable iff (reset_in)
        read_in |=> read_data_out[BIT_HALT] == $past(halt_request))
        else $error("halt bit read wrong");

    a_enable_port: assert property (@(posedge clock_in) disable iff (reset_in)
        write_in && !from_access_port_in |=> $stable(debug_enable))
        else $error("core wrote enable");

    a_enable_write: assert property (@(posedge clock_in) disable iff (reset_in)
        write_ok && from_access_port_in |=> debug_enable == $past(write_data_in[BIT_DEBUG_EN]))
        else $error("port write to enable lost");

    a_step_out: assert property (@(posedge clock_in) disable iff (reset_in)
        debug_enable && step_enable |=> step_out)
        else $error("step enable not applied");

    a_reserved_zero: assert property (@(posedge clock_in) disable iff (reset_in)
        read_data_out[31:26] == 6'h00 && read_data_out[23:20] == 4'h0
            && read_data_out[15:4] == 12'h000)
        else $error("reserved bits nonzero");

    // Cover points for the main scenarios
    c_halt: cover property (@(posedge clock_in) disable iff (reset_in) halt_out);
    c_step: cover property (@(posedge clock_in) disable iff (reset_in) step_out);
    c_ready: cover property (@(posedge clock_in) disable iff (reset_in)
        selector_write_in ##[1:20] transfer_done_in);
    c_lock: cover property (@(posedge clock_in) disable iff (reset_in) lockup_status);
    c_sleep_halt: cover property (@(posedge clock_in) disable iff (reset_in)
        sleeping && halt_out);
endmodule // halting_debug_control_status
`default_nettype wire

// ---- rtl/sticky_flag.sv ----
// Sticky status flag where a set beats a same-cycle clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
    input  wire logic clock_in,
    input  wire logic reset_in,
    input  wire logic reset_value_in,
    input  wire logic set_in,
    input  wire logic clear_in,
    output var  logic flag_out
);
    // Set has priority so no event is lost
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            flag_out <= reset_value_in;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule // sticky_flag
`default_nettype wire

// ---- shared/debug_ctrl_if.sv ----
// Control bits handed from the register to the gating logic
`timescale 1ns/1ps
`default_nettype none
interface debug_ctrl_if;
    logic debug_enable;
    logic halt_request;
    logic step_enable;
    logic mask_request;
    logic effective_halt;
    logic effective_step;
    logic effective_mask;

    modport source (output debug_enable, output halt_request, output step_enable,
                    output mask_request, input effective_halt, input effective_step,
                    input effective_mask);
    modport gate   (input debug_enable, input halt_request, input step_enable,
                    input mask_request, output effective_halt, output effective_step,
                    output effective_mask);
endinterface : debug_ctrl_if
`default_nettype wire

// ---- shared/debug_status_pkg.sv ----
// Constants and types for the halting debug control and status block
package debug_status_pkg;
    localparam logic [15:0] UNLOCK_KEY      = 16'ha05f;
    localparam int          KEY_LSB         = 16;
    localparam int          BIT_RESET_SEEN  = 25;
    localparam int          BIT_RETIRED     = 24;
    localparam int          BIT_LOCKUP      = 19;
    localparam int          BIT_SLEEP       = 18;
    localparam int          BIT_HALTED      = 17;
    localparam int          BIT_XFER_READY  = 16;
    localparam int          BIT_MASK_INTS   = 3;
    localparam int          BIT_STEP        = 2;
    localparam int          BIT_HALT        = 1;
    localparam int          BIT_DEBUG_EN    = 0;
    localparam logic        RESET_SEEN_INIT = 1'b1;
    localparam logic        CTRL_RESET_VAL  = 1'b0;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    // Core run state as seen by the debug logic
    typedef enum logic [1:0] {
        CORE_RUN    = 2'b00,
        CORE_SLEEP  = 2'b01,
        CORE_LOCKED = 2'b10,
        CORE_HALTED = 2'b11
    } core_state_e;
endpackage : debug_status_pkg

// ---- sim/debugger_model.sv ----
// Debugger model that drives the register through the debug access port or from the core side
`timescale 1ns/1ps
`default_nettype none
module debugger_model (
    input  wire logic        clock_in,
    input  wire logic [31:0] read_data_in,
    output var  logic        write_out,
    output var  logic        read_out,
    output var  logic        port_out,
    output var  logic [31:0] data_out
);
    import debug_status_pkg::*;

    // Idle bus from time zero
    initial begin
        write_out = 1'b0;
        read_out  = 1'b0;
        port_out  = 1'b1;
        data_out  = ZERO_WORD;
    end

    // One write; the random callers always pass a wrong key, so their writes change nothing
    task automatic put(input logic [31:0] word, input logic from_port);
        // Callers in the words they pass
        @(posedge clock_in);
        #1;
        write_out = 1'b1;
        port_out  = from_port;
        data_out  = word;
        @(posedge clock_in);
        #1;
        write_out = 1'b0;
        data_out  = ~word; // Stale data must not look valid
    endtask

    // One read; the word is taken at the edge after the strobe
    task automatic get(input logic from_port, output logic [31:0] word);
        @(posedge clock_in);
        #1;
        read_out = 1'b1;
        port_out = from_port;
        @(posedge clock_in);
        #1;
        read_out = 1'b0;
        word     = read_data_in;
    endtask
endmodule // debugger_model
`default_nettype wire

// ---- sim/halting_debug_control_status_tb.sv ----
// Self-checking bench for the halting debug control and status block
`timescale 1ns/1ps
`default_nettype none
module halting_debug_control_status_tb;
    import debug_status_pkg::*;
    logic        clock;
    logic        reset;
    logic        system_reset;
    logic        sel_write, xfer_done, instr_done;
    core_state_e state;
    logic        write, read, port;
    logic [31:0] wdata, rdata, r;
    logic        halt_o, step_o, mask_o;
    logic        en, halt, step, mask, rs, ret, rdy;
    logic [15:0] key;
    int          seed = 65;
    int          n_mismatch = 0;
    int          total_checks = 0;

    halting_debug_control_status dut (
        .clock_in(clock), .reset_in(reset), .system_reset_in(system_reset),
        .write_in(write), .read_in(read), .from_access_port_in(port),
        .write_data_in(wdata), .selector_write_in(sel_write),
        .transfer_done_in(xfer_done), .instruction_done_in(instr_done),
        .core_state_in(state), .read_data_out(rdata), .halt_out(halt_o),
        .step_out(step_o), .mask_interrupts_out(mask_o));

    debugger_model dbg (
        .clock_in(clock), .read_data_in(rdata), .write_out(write),
        .read_out(read), .port_out(port), .data_out(wdata));

    // Free-running 100 MHz clock
    always #5 clock = ~clock;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    // Control outputs are the enable ANDed with each stored bit
    task automatic check_ctrl();
        logic [2:0] exp;
        exp = {en & halt, en & step, en & mask};
        total_checks++;
        if ({halt_o, step_o, mask_o} !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time,
                     {halt_o, step_o, mask_o}, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] expect_word(input logic from_port);
        logic [31:0] w;
        w                 = ZERO_WORD;
        w[BIT_RESET_SEEN] = rs;
        w[BIT_RETIRED]    = ret;
        w[BIT_LOCKUP]     = (state == CORE_LOCKED) && from_port;
        w[BIT_SLEEP]      = state == CORE_SLEEP;
        w[BIT_HALTED]     = state == CORE_HALTED;
        w[BIT_XFER_READY] = rdy;
        w[3:0]            = {mask, step, halt, en};
        return w;
    endfunction

    // Undefined bits are left out of the comparison
    task automatic rd_check(input logic from_port);
        logic [31:0] got, exp, care;
        exp  = expect_word(from_port);
        care = 32'hffff_ffff;
        if (state == CORE_LOCKED || state == CORE_HALTED) care[BIT_RETIRED] = 1'b0;
        if (state != CORE_HALTED) care[BIT_XFER_READY] = 1'b0;
        if (!en) care[BIT_MASK_INTS] = 1'b0;
        dbg.get(from_port, got);
        check_word(got & care, exp & care);
        rs  = 1'b0;
        ret = 1'b0;
    endtask

    task automatic wr(input logic [31:0] word, input logic from_port);
        dbg.put(word, from_port);
        if (word[31:16] == UNLOCK_KEY) begin
            if (from_port) en = word[BIT_DEBUG_EN];
            {mask, step, halt} = word[3:1];
        end
        @(posedge clock);
        #1;
        check_ctrl();
    endtask

    // Event pulses, then an idle edge so registered core state settles
    task automatic events(input logic s, input logic d, input logic i);
        @(posedge clock);
        #1;
        sel_write  = s;
        xfer_done  = d;
        instr_done = i;
        if (d) rdy = 1'b1;
        else if (s) rdy = 1'b0;
        if (i && state != CORE_HALTED) ret = 1'b1;
        @(posedge clock);
        #1;
        {sel_write, xfer_done, instr_done} = 3'b000;
        @(posedge clock);
        #1;
    endtask

    // Main sequence
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        system_reset = 1'b0;
        {sel_write, xfer_done, instr_done} = 3'b000;
        state = CORE_RUN;
        {en, halt, step, mask, ret, rdy} = 6'h00;
        rs = RESET_SEEN_INIT;
        repeat (16) @(posedge clock);
        #1;
        reset = 1'b0;
        rd_check(1'b1);
        rd_check(1'b1);
        done("reset");
        wr(32'h1234_000f, 1'b1);
        wr(32'ha05f_0003, 1'b0);
        rd_check(1'b1);
        wr(32'ha05f_0003, 1'b1);
        // Step and mask are set by this write, made with the core halted
        state = CORE_HALTED;
        wr(32'ha05f_000f, 1'b1);
        rd_check(1'b1);
        wr(32'ha05f_0003, 1'b1);
        state = CORE_RUN;
        wr(32'ha05f_0001, 1'b1);
        // Debugger takes control of a sleeping core by halting it
        state = CORE_SLEEP;
        wr(32'ha05f_0003, 1'b1);
        rd_check(1'b1);
        state = CORE_RUN;
        done("control");
        @(posedge clock);
        #1;
        system_reset = 1'b1;
        @(posedge clock);
        #1;
        system_reset = 1'b0;
        rs = 1'b1;
        halt = 1'b0;
        @(posedge clock);
        #1;
        check_ctrl();
        rd_check(1'b1);
        done("system reset");
        state = CORE_HALTED;
        events(1'b1, 1'b0, 1'b0);
        rd_check(1'b1);
        events(1'b0, 1'b1, 1'b0);
        rd_check(1'b1);
        state = CORE_LOCKED;
        events(1'b0, 1'b0, 1'b0);
        rd_check(1'b1);
        rd_check(1'b0);
        state = CORE_RUN;
        events(1'b0, 1'b0, 1'b1);
        rd_check(1'b1);
        done("status");
        repeat (60) begin
            r = $random(seed);
            state = core_state_e'(r[1:0]);
            events(r[2], r[3], r[4]);
            rd_check(r[5]);
            key = (r[31:16] == UNLOCK_KEY) ? 16'h0000 : r[31:16];
            wr({key, r[15:0]}, r[6]);
        end
        done("random");
        // Power-on reset mid-run must clear the enable and the halt
        state = CORE_RUN;
        events(1'b0, 1'b0, 1'b0);
        wr(32'ha05f_0003, 1'b1);
        reset = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        reset = 1'b0;
        {en, halt, step, mask, ret, rdy} = 6'h00;
        rs = RESET_SEEN_INIT;
        check_ctrl();
        rd_check(1'b1);
        done("power-on reset");
        finish_test();
    end

    // Watchdog far beyond the roughly six hundred cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule // halting_debug_control_status_tb
`default_nettype wire
